// ===== i2c_target_register_port.sv
// Two-wire target port giving a bus master access to a byte register space.
// Assumes SCL/SDA as plain inputs with open-drain SDA output; pull-ups are external.
// Summary of operation
// - The port acts only as a target and handles 100 kb/s and 400 kb/s traffic.
// - The bus address defaults to 0x2B.
// - A programmed nonvolatile address word replaces the default address.
// - Reads and writes are taken at any time, with no mode prerequisite.
// - Status bytes are read-only inputs and control bytes are read and write.
// - A write starts with the address and a zero direction bit, which is acknowledged.
// - The first written byte is the register pointer, and every byte is acknowledged.
// - The pointer increments after each written data byte.
// - An address with direction one is acknowledged and the first read byte driven.
// - The pointer advances after each read byte; a master acknowledge makes the port send the next register.
// - Gateway bytes are held in volatile flops and lost on reset.
`timescale 1ns/100ps
module i2c_target_register_port
  import i2c_target_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Nonvolatile address slot
  input wire logic nvm_addr_valid_i,
  input wire logic [6:0] nvm_addr_i,
  // Read-only status bytes, mapped at the low register indices
  input wire logic [7:0] status0_i,
  input wire logic [7:0] status1_i,
  // Write strobe towards the device core
  output i2c_target_pkg::reg_wr_t reg_wr_o
);

  // ==========================================================
  // State
  typedef struct packed {
    line_t s1;
    line_t s2;
    line_t prev;
    phase_t phase;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic reading;
    logic ptr_next;
    logic [7:0] ptr;
    logic [6:0] own_addr;
    logic addr_loaded;
    logic sda_drv;
    reg_wr_t wr;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [7:0] regs_q [0:REG_COUNT-1];
  logic [7:0] rd_byte;

  // Status bytes stand at index 0 and 1; software writes there are dropped
  function automatic logic is_status(input logic [7:0] a);
    return a < 8'h02;
  endfunction

  // ==========================================================
  // Read mux
  always_comb begin
    if (st_q.ptr == 8'h00) begin
      rd_byte = status0_i;
    end else if (st_q.ptr == 8'h01) begin
      rd_byte = status1_i;
    end else begin
      rd_byte = regs_q[st_q.ptr];
    end
  end

  // ==========================================================
  // Protocol engine; SDA is sampled on SCL rise, changed on SCL fall
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    st_d = st_q;
    st_d.s1 = '{scl: scl_i, sda: sda_i};
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
    st_d.wr.wr = 1'b0;
    // edge detection on synced lines, ample margin at 400 kb/s
    scl_rise = st_q.s2.scl & ~st_q.prev.scl;
    scl_fall = ~st_q.s2.scl & st_q.prev.scl;
    start_c = st_q.s2.scl & st_q.prev.scl & st_q.prev.sda & ~st_q.s2.sda;
    stop_c = st_q.s2.scl & st_q.prev.scl & ~st_q.prev.sda & st_q.s2.sda;
    // address taken once after reset release
    if (!st_q.addr_loaded) begin
      st_d.addr_loaded = 1'b1;
      st_d.own_addr = nvm_addr_valid_i ? nvm_addr_i : DEFAULT_BUS_SELECT_CODE;
    end
    if (stop_c) begin
      st_d.phase = ST_IDLE;
      st_d.sda_drv = 1'b0;
    end else if (start_c) begin
      // start or repeated start at any time
      st_d.phase = ST_ADDR;
      st_d.bitn = 4'h0;
      st_d.sda_drv = 1'b0;
    end else begin
      case (st_q.phase)
        ST_IDLE: begin
          st_d.sda_drv = 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            st_d.shreg = {st_q.shreg[6:0], st_q.s2.sda};
            st_d.bitn = st_q.bitn + 4'h1;
          end else if (scl_fall && st_q.bitn == BIT_ACK) begin
            st_d.bitn = 4'h0;
            if (st_q.phase == ST_ADDR) begin
              if (st_q.shreg[7:1] == st_q.own_addr) begin
                st_d.sda_drv = 1'b1;
                st_d.reading = st_q.shreg[0];
                st_d.ptr_next = 1'b1;
                st_d.phase = ST_ADDR_ACK;
              end else begin
                st_d.phase = ST_IDLE;
              end
            end else begin
              st_d.sda_drv = 1'b1;
              st_d.phase = ST_WRITE_ACK;
              if (st_q.ptr_next) begin
                st_d.ptr = st_q.shreg;
                st_d.ptr_next = 1'b0;
              end else begin
                st_d.wr = '{wr: 1'b1, addr: st_q.ptr, data: st_q.shreg};
                st_d.ptr = st_q.ptr + 8'h01;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_WRITE_ACK: begin
          if (scl_fall) begin
            if (st_q.phase == ST_ADDR_ACK && st_q.reading) begin
              // first read byte drives on ack release
              st_d.shreg = rd_byte;
              st_d.sda_drv = ~rd_byte[7];
              st_d.bitn = 4'h0;
              st_d.phase = ST_READ;
            end else begin
              st_d.sda_drv = 1'b0;
              st_d.phase = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (st_q.bitn == BIT_LAST) begin
              st_d.sda_drv = 1'b0;
              st_d.ptr = st_q.ptr + 8'h01;
              st_d.phase = ST_READ_ACK;
            end else begin
              st_d.shreg = {st_q.shreg[6:0], 1'b0};
              st_d.sda_drv = ~st_q.shreg[6];
              st_d.bitn = st_q.bitn + 4'h1;
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            st_d.phase = st_q.s2.sda ? ST_IDLE : ST_ADDR_ACK;
            st_d.reading = 1'b1;
          end
        end
        default: begin
          st_d.phase = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '{s1: '{scl: 1'b1, sda: 1'b1}, s2: '{scl: 1'b1, sda: 1'b1},
                prev: '{scl: 1'b1, sda: 1'b1}, phase: ST_IDLE, bitn: 4'h0,
                shreg: BYTE_ZERO, reading: 1'b0, ptr_next: 1'b0, ptr: POINTER_RESET,
                own_addr: DEFAULT_BUS_SELECT_CODE, addr_loaded: 1'b0, sda_drv: 1'b0,
                wr: '{wr: 1'b0, addr: BYTE_ZERO, data: BYTE_ZERO}};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Control and gateway bytes; cleared on reset as they are volatile
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= BYTE_ZERO;
      end
    end else if (st_q.wr.wr && !is_status(st_q.wr.addr)) begin
      regs_q[st_q.wr.addr] <= st_q.wr.data;
    end
  end

  // Open drain: output level is always low, enable pulls the line
  assign sda_o = 1'b0;
  assign sda_oe_o = st_q.sda_drv;
  assign reg_wr_o = st_q.wr;

endmodule

// ===== i2c_target_pkg.sv
// Constants and carrier types for the two-wire target register port.
// Assumes a single 20 MHz core clock; SCL and SDA arrive asynchronously.
package i2c_target_pkg;

  // ==========================================================
  // Bus address
  localparam logic [6:0] DEFAULT_BUS_SELECT_CODE = 7'h2B;
  localparam logic [7:0] NVM_ADDR_SLOT = 8'h04;

  // ==========================================================
  // Register space
  localparam int REG_COUNT = 256;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // ==========================================================
  // Link phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_READ_ACK = 3'b110
  } phase_t;

  // Sampled line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;

  // Register-file access strobe
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

endpackage

// ===== i2c_target_register_port_checker.sv
// Checker for the two-wire target port, bound to its top module.
// Assumes SCL low phases outlast the target's input sync lag.
`timescale 1ns/100ps
module i2c_target_register_port_checker
  import i2c_target_pkg::*;
(
  // Clock, reset and link
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Core side
  input wire logic nvm_addr_valid_i,
  input wire logic [6:0] nvm_addr_i,
  input wire logic [7:0] status0_i,
  input wire logic [7:0] status1_i,
  input wire i2c_target_pkg::reg_wr_t reg_wr_o
);
  // ==========
  // Cycles of SCL high; a long run means an idle bus
  logic [4:0] high_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) high_q <= 5'h00;
    else if (!scl_i) high_q <= 5'h00;
    else if (high_q != 5'h1F) high_q <= high_q + 5'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Any drive must hold for at least four core clock cycles
  sequence s_drive_hold;
    sda_oe_o [*4];
  endsequence
  open_drain_a: assert property (sda_o == 1'b0)
    else $error("sda_o high");
  reset_quiet_a: assert property (disable iff (1'b0) !arst_n_i |-> !sda_oe_o)
    else $error("drive in reset");
  drive_hold_a: assert property ($rose(sda_oe_o) |-> s_drive_hold)
    else $error("drive too short");
  edge_safe_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved, scl high");
  strobe_once_a: assert property (reg_wr_o.wr |=> !reg_wr_o.wr)
    else $error("strobe too long");
  strobe_ack_a: assert property (reg_wr_o.wr |-> ##[0:2] sda_oe_o)
    else $error("strobe without ack");
  strobe_low_a: assert property (reg_wr_o.wr |-> !scl_i)
    else $error("strobe, scl high");
  idle_release_a: assert property (high_q >= 5'h10 |-> !sda_oe_o)
    else $error("sda held when idle");
endmodule
bind i2c_target_register_port i2c_target_register_port_checker i_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .nvm_addr_valid_i(nvm_addr_valid_i), .nvm_addr_i(nvm_addr_i),
  .status0_i(status0_i), .status1_i(status1_i), .reg_wr_o(reg_wr_o));

// ===== i2c_host_model.sv
// Bus master model: drives SCL and pulls SDA low, 400 ns per bit.
// Assumes a pull-up resolves SDA in the bench.
`timescale 1ns/100ps
module i2c_host_model (
  // Bus lines
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  // ==========
  // SCL stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // One bit: data set early in the long low phase, sampled at the rise
  task automatic bit_x(input logic v, output logic s);
    #100;
    sda_oe_o = !v;
    #200;
    scl_o = 1'b1;
    s = sda_i;
    #100;
    scl_o = 1'b0;
  endtask
  task automatic start();
    #100;
    sda_oe_o = 1'b0;
    #300;
    scl_o = 1'b1;
    #200;
    sda_oe_o = 1'b1;
    #200;
    scl_o = 1'b0;
  endtask
  task automatic stop();
    #100;
    sda_oe_o = 1'b1;
    #300;
    scl_o = 1'b1;
    #200;
    sda_oe_o = 1'b0;
    #400;
  endtask
  // eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] b, input logic a9, output logic [7:0] r, output logic s9);
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r[i]);
    end
    bit_x(a9, s9);
  endtask
endmodule

// ===== test_i2c_target_register_port.sv
// Self-checking bench for the two-wire target port.
// Assumes the master model and an SDA pull-up stand in for the host.
`timescale 1ns/100ps
module test_i2c_target_register_port;
  import i2c_target_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic nvm_valid = 1'b0;
  logic [6:0] nvm_addr = 7'h00;
  logic [6:0] own = DEFAULT_BUS_SELECT_CODE;
  logic [7:0] st0 = 8'hC3;
  logic [7:0] st1 = 8'h5A;
  logic scl, host_oe, dut_oe, dut_sda;
  reg_wr_t wr;
  logic [15:0] wq[$];
  int fails = 0;
  int total_checks = 0;
  // Open-drain line with pull-up
  wire sda = !(host_oe || dut_oe);
  always #25 clk = ~clk;
  i2c_host_model i_host (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
  i2c_target_register_port i_dut (.clk_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(dut_sda), .sda_oe_o(dut_oe), .nvm_addr_valid_i(nvm_valid), .nvm_addr_i(nvm_addr),
    .status0_i(st0), .status1_i(st1), .reg_wr_o(wr));
  // Log of write strobes towards the core
  // Read at the falling edge, where the registered strobe has settled
  always @(negedge clk) if (wr.wr === 1'b1) wq.push_back({wr.addr, wr.data});
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Acknowledge levels and read bytes get compares of their own width
  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk({8'h00, got}, {8'h00, exp});
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic v, input logic [6:0] a);
    @(posedge clk);
    #5;
    arst_n = 1'b0;
    nvm_valid = v;
    nvm_addr = a;
    repeat (8) @(posedge clk);
    #5;
    arst_n = 1'b1;
    repeat (4) @(posedge clk);
    // Keep every host edge off the sampling edge of the core clock
    #5;
  endtask
  // Address and pointer phase; lv is the expected ninth-bit level
  task automatic head(input logic [6:0] a, input logic [7:0] p, input logic lv);
    logic k;
    logic [7:0] r;
    i_host.start();
    i_host.xfer({a, 1'b0}, 1'b1, r, k);
    chk_bit(k, lv);
    i_host.xfer(p, 1'b1, r, k);
    chk_bit(k, lv);
  endtask
  task automatic wr_seq(input logic [7:0] p, input int n, input logic [31:0] d);
    logic k;
    logic [7:0] r;
    wq.delete();
    head(own, p, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(d[31 - 8 * i -: 8], 1'b1, r, k);
      chk_bit(k, 1'b0);
    end
    i_host.stop();
    chk(16'(wq.size()), 16'(n));
    for (int i = 0; i < n; i++) begin
      chk(wq[i], {p + 8'(i), d[31 - 8 * i -: 8]});
    end
  endtask
  task automatic rd(input logic [7:0] p, input int n, input logic [31:0] e);
    logic k;
    logic [7:0] b;
    head(own, p, 1'b0);
    i_host.start();
    i_host.xfer({own, 1'b1}, 1'b1, b, k);
    chk_bit(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'hFF, i == n - 1, b, k);
      chk_byte(b, e[31 - 8 * i -: 8]);
    end
    i_host.stop();
  endtask
  // Burst write, pointer wrap and burst read back
  task automatic t_burst();
    wr_seq(8'h10, 3, 32'hA53C_0F00);
    rd(8'h10, 3, 32'hA53C_0F00);
    wr_seq(8'hFF, 2, 32'h9677_0000);
    rd(8'hFF, 2, {8'h96, st0, 16'h0000});
  endtask
  // Status bytes keep their live value when written
  task automatic t_status();
    wr_seq(8'h00, 2, 32'h1122_0000);
    rd(8'h00, 2, {st0, st1, 16'h0000});
  endtask
  // Foreign address refused; programmed address after a fresh reset
  task automatic t_address();
    head(own ^ 7'h01, 8'h10, 1'b1);
    i_host.stop();
    rd(8'h10, 1, 32'hA500_0000);
    do_reset(1'b1, 7'h51);
    head(DEFAULT_BUS_SELECT_CODE, 8'h10, 1'b1);
    i_host.stop();
    own = 7'h51;
    rd(8'h10, 1, 32'h0000_0000);
  endtask
  initial begin
    // Early falling edge resets every flop before the first clock edge
    #1;
    arst_n = 1'b0;
    do_reset(1'b0, 7'h00);
    t_burst();
    t_status();
    t_address();
    final_report();
  end
  // Watchdog: the run needs well under half a millisecond
  initial begin
    #1_000_000;
    fails++;
    final_report();
  end
endmodule
